// ==== include/pmalrt_pkg.sv ====
package pmalrt_pkg;
	// ----------------------------------------------------------------
	// bus addresses and commands
	// ----------------------------------------------------------------
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
	localparam logic [6:0] ADDR_BASE       = 7'h20;
	localparam logic [7:0] CMD_CLEAR       = 8'h03;
	localparam logic [7:0] CMD_STATUS      = 8'h79;
	localparam logic [7:0] CMD_READ_VIN    = 8'h88;
	localparam logic [7:0] CMD_READ_VOUT   = 8'h8B;
	localparam logic [7:0] CMD_READ_IOUT   = 8'h8C;
	localparam logic [7:0] CMD_READ_TEMP   = 8'h8D;
	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] FAULT_RESET     = 8'h00;
	localparam logic [3:0] BIT_LAST        = 4'h8;
	localparam logic [2:0] SYNC_DIV_RESET  = 3'h0;

	typedef enum logic [2:0] {
		PMALRT_IDLE  = 3'b000,
		PMALRT_ADDR  = 3'b001,
		PMALRT_CMD   = 3'b010,
		PMALRT_RDATA = 3'b011,
		PMALRT_HALT  = 3'b100
	} pmalrt_state_t;

	// analog-side measurements presented to the bus
	typedef struct packed {
		logic [7:0] vin;
		logic [7:0] vout;
		logic [7:0] iout;
		logic [7:0] temp;
	} pmalrt_meas_t;

	// fault events from the comparators
	typedef struct packed {
		logic ov1;
		logic ov2;
		logic oc;
		logic ot;
		logic uv_in;
	} pmalrt_fault_t;
endpackage

// ==== verilog/pmalrt_sync.sv ====
`timescale 1ns/1ns
module pmalrt_sync
	import pmalrt_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// async in, synced out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
		end
	end
	assign dout = stage2;
endmodule // pmalrt_sync

// ==== verilog/pmalrt_top.sv ====
// Summary of operation
// - acts as a two-wire bus slave following standard transaction rules.
// - alert output pulled low when any configured fault occurs.
// - alert stays low until the host sends the clear command; the response read leaves it low.
// - halted bus interface recovers by disabling then re-enabling the module.
// - input/output voltage, current, temperature and fault status readable.
// - each output has its own enable input turning it on.
// - separate push-pull power-good output per rail.
// - slave address taken from strapped address-select value.
// - external sync clock sets switching frequency.
// - output overvoltage drops power-good and latches the output off.
`timescale 1ns/1ns
module pmalrt_top
	import pmalrt_pkg::*;
(
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// serial bus pins
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe_n,
	output logic               fault_alert_out,
	// enables and straps
	input  wire logic          output_one_enable_in,
	input  wire logic          output_two_enable_in,
	input  wire logic [2:0]    addr_strap,
	input  wire logic          sync_in,
	// analog side
	input  wire pmalrt_meas_t  meas,
	input  wire pmalrt_fault_t fault_in,
	input  wire logic [1:0]    rail_in_reg,
	output logic               output_one_power_good,
	output logic               output_two_power_good,
	output logic               rail_one_on,
	output logic               rail_two_on,
	output logic               switch_clk
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic [4:0] flt_s;
	logic [1:0] reg_s;

	pmalrt_sync #(.W(5)) u_sync_pins (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({scl_in, sda_in, output_one_enable_in, output_two_enable_in, sync_in}),
		.dout    (pins_s)
	);
	pmalrt_sync #(.W(5)) u_sync_flt (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (fault_in),
		.dout    (flt_s)
	);
	pmalrt_sync #(.W(2)) u_sync_reg (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (rail_in_reg),
		.dout    (reg_s)
	);

	logic scl, sda, en1, en2, sync_s;
	assign {scl, sda, en1, en2, sync_s} = pins_s;

	// ----------------------------------------------------------------
	// edge detect, strap capture, rails
	// ----------------------------------------------------------------
	logic       scl_d, sda_d, sync_d, en_any_d;
	logic [6:0] my_addr, next_my_addr;
	logic       strap_done, next_strap_done;
	logic       latch1, latch2, next_latch1, next_latch2;
	logic       next_rail1, next_rail2, next_pg1, next_pg2, next_swclk;

	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c  = scl & sda_d & ~sda;
	wire stop_c   = scl & ~sda_d & sda;
	wire en_any   = en1 | en2;
	wire reen     = en_any & ~en_any_d;

	always_comb begin
		next_strap_done = 1'b1;
		// strap sampled after reset release
		next_my_addr    = strap_done ? my_addr : (ADDR_BASE | {4'h0, addr_strap});
		// overvoltage latches the rail off until re-enable; for rail one that re-enable must come with en1 high
		next_latch1     = (latch1 & ~(reen & ~en1 ? 1'b0 : reen)) | flt_s[4];
		next_latch2     = (latch2 & ~reen) | flt_s[3];
		next_rail1      = en1 & ~next_latch1;
		next_rail2      = en2 & ~next_latch2;
		// separate push-pull indications per rail
		next_pg1        = next_rail1 & reg_s[0] & ~flt_s[4];
		next_pg2        = next_rail2 & reg_s[1] & ~flt_s[3];
		// switching clock toggles on each rising edge of the external sync input
		next_swclk      = (sync_s & ~sync_d) ? ~switch_clk : switch_clk;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_d                 <= 1'b1;
			sda_d                 <= 1'b1;
			sync_d                <= 1'b0;
			en_any_d              <= 1'b0;
			strap_done            <= 1'b0;
			my_addr               <= ADDR_BASE;
			latch1                <= 1'b0;
			latch2                <= 1'b0;
			rail_one_on           <= 1'b0;
			rail_two_on           <= 1'b0;
			output_one_power_good <= 1'b0;
			output_two_power_good <= 1'b0;
			switch_clk            <= 1'b0;
		end else begin
			scl_d                 <= scl;
			sda_d                 <= sda;
			sync_d                <= sync_s;
			en_any_d              <= en_any;
			strap_done            <= next_strap_done;
			my_addr               <= next_my_addr;
			latch1                <= next_latch1;
			latch2                <= next_latch2;
			rail_one_on           <= next_rail1;
			rail_two_on           <= next_rail2;
			output_one_power_good <= next_pg1;
			output_two_power_good <= next_pg2;
			switch_clk            <= next_swclk;
		end
	end

	// ----------------------------------------------------------------
	// fault record and alert
	// ----------------------------------------------------------------
	logic [7:0] fault_rec, next_fault_rec;
	logic       clear_req;
	logic       next_alert;

	always_comb begin
		// a new event wins over a same-cycle clear
		next_fault_rec = (clear_req ? 8'h00 : fault_rec) | {3'h0, flt_s};
		// open-drain style, low while anything is pending
		next_alert     = ~(|next_fault_rec);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fault_rec       <= FAULT_RESET;
			fault_alert_out <= 1'b1;
		end else begin
			fault_rec       <= next_fault_rec;
			fault_alert_out <= next_alert;
		end
	end

	// ----------------------------------------------------------------
	// serial slave
	// ----------------------------------------------------------------
	pmalrt_state_t state, next_state;
	logic [3:0]    bitc, next_bitc;
	logic [7:0]    shreg, next_shreg;
	logic [7:0]    cmd, next_cmd;
	logic          ack, next_ack;
	logic          ara, next_ara;
	logic          next_sda_out, next_sda_oe_n;

	function automatic logic [7:0] read_sel(input logic [7:0] c, input pmalrt_meas_t m, input logic [7:0] f);
		if (c == CMD_READ_VIN)       read_sel = m.vin;
		else if (c == CMD_READ_VOUT) read_sel = m.vout;
		else if (c == CMD_READ_IOUT) read_sel = m.iout;
		else if (c == CMD_READ_TEMP) read_sel = m.temp;
		else                         read_sel = f;
	endfunction

	always_comb begin
		next_state    = state;
		next_bitc     = bitc;
		next_shreg    = shreg;
		next_cmd      = cmd;
		next_ack      = ack;
		next_ara      = ara;
		next_sda_out  = sda_out;
		next_sda_oe_n = sda_oe_n;
		clear_req     = 1'b0;
		if (state == PMALRT_HALT) begin
			// only a fresh enable brings the interface back
			if (reen) begin
				next_state    = PMALRT_IDLE;
				next_sda_oe_n = 1'b1;
			end
		end else if (start_c) begin
			next_state    = PMALRT_ADDR;
			next_bitc     = 4'h0;
			next_ack      = 1'b0;
			next_sda_oe_n = 1'b1;
		end else if (stop_c) begin
			next_state    = PMALRT_IDLE;
			next_sda_oe_n = 1'b1;
			// cleared on stop once a clear command was taken
			// the stop's own clock rise shifts one extra bit in
			clear_req     = (cmd == CMD_CLEAR) & (bitc < 4'h2) & ~ara;
			next_cmd      = 8'h00;
		end else if (scl_rise & ~ack & state != PMALRT_IDLE) begin
			next_shreg = {shreg[6:0], sda};
			next_bitc  = bitc + 4'h1;
		end else if (scl_fall & state != PMALRT_IDLE) begin
			if (ack) begin
				next_ack      = 1'b0;
				next_bitc     = 4'h0;
				next_sda_oe_n = 1'b1;
				if (state == PMALRT_RDATA && !sda_oe_n) begin
					next_sda_oe_n = 1'b0;
					next_sda_out  = shreg[7];
				end else if (state == PMALRT_RDATA) begin
					// host nack ends the read; a host ack asks for more and halts
					next_state = sda ? PMALRT_IDLE : PMALRT_HALT;
				end
			end else if (bitc == BIT_LAST) begin
				next_ack = 1'b1;
				if (state == PMALRT_ADDR) begin
					// response address answers only while alerting
					next_ara = (shreg[7:1] == ALERT_RESP_ADDR) & ~fault_alert_out;
					if (shreg[7:1] == my_addr || next_ara) begin
						next_sda_oe_n = 1'b0;
						next_sda_out  = 1'b0;
						next_state    = shreg[0] ? PMALRT_RDATA : PMALRT_CMD;
						// reading back our address or the selected value
						next_shreg    = next_ara ? {my_addr, 1'b0} : read_sel(cmd, meas, fault_rec);
					end else begin
						next_state = PMALRT_IDLE;
						next_ack   = 1'b0;
					end
				end else if (state == PMALRT_CMD) begin
					next_cmd      = shreg;
					next_bitc     = 4'h0;
					next_sda_oe_n = 1'b0;
					next_sda_out  = 1'b0;
				end else begin
					// let go so the host can answer the byte
					next_sda_oe_n = 1'b1;
				end
			end else if (state == PMALRT_RDATA) begin
				// each rise has shifted the next bit up to the top
				next_sda_out  = shreg[7];
				next_sda_oe_n = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state    <= PMALRT_IDLE;
			bitc     <= 4'h0;
			shreg    <= 8'h00;
			cmd      <= 8'h00;
			ack      <= 1'b0;
			ara      <= 1'b0;
			sda_out  <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			state    <= next_state;
			bitc     <= next_bitc;
			shreg    <= next_shreg;
			cmd      <= next_cmd;
			ack      <= next_ack;
			ara      <= next_ara;
			sda_out  <= next_sda_out;
			sda_oe_n <= next_sda_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_alert_fault;
		@(posedge clk_sys) disable iff (rst) (|flt_s) |=> !fault_alert_out;
	endproperty
	a_alert_fault: assert property (p_alert_fault) else $error("alert not asserted on fault");

	property p_alert_hold;
		@(posedge clk_sys) disable iff (rst) (|fault_rec && !clear_req) |=> !fault_alert_out;
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert released with fault pending");

	property p_alert_release;
		@(posedge clk_sys) disable iff (rst) (clear_req && !(|flt_s)) |=> fault_alert_out;
	endproperty
	a_alert_release: assert property (p_alert_release) else $error("alert held after clear");

	property p_ov_pg;
		@(posedge clk_sys) disable iff (rst) flt_s[4] |=> !output_one_power_good ##1 !rail_one_on;
	endproperty
	a_ov_pg: assert property (p_ov_pg) else $error("power good kept on overvoltage");

	property p_enable;
		@(posedge clk_sys) disable iff (rst) (!en2) |=> !rail_two_on;
	endproperty
	a_enable: assert property (p_enable) else $error("rail on without enable");

	property p_halt_recover;
		@(posedge clk_sys) disable iff (rst) (state == PMALRT_HALT && reen) |=> state == PMALRT_IDLE;
	endproperty
	a_halt_recover: assert property (p_halt_recover) else $error("no recovery on re-enable");

	property p_halt_stays;
		@(posedge clk_sys) disable iff (rst) (state == PMALRT_HALT && !reen) |=> state == PMALRT_HALT;
	endproperty
	a_halt_stays: assert property (p_halt_stays) else $error("halt left without enable");

	property p_stop_idle;
		@(posedge clk_sys) disable iff (rst) (stop_c && state != PMALRT_HALT) |=> state == PMALRT_IDLE && sda_oe_n;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

	property p_strap;
		@(posedge clk_sys) disable iff (rst) strap_done |=> $stable(my_addr);
	endproperty
	a_strap: assert property (p_strap) else $error("address changed after strap");

	property p_pg_sep;
		@(posedge clk_sys) disable iff (rst) (!rail_two_on) |-> !output_two_power_good;
	endproperty
	a_pg_sep: assert property (p_pg_sep) else $error("power good without rail");
endmodule // pmalrt_top

// ==== tb/pmalrt_host.sv ====
`timescale 1ns/1ns
module pmalrt_host
	import pmalrt_pkg::*;
(
	// clock
	input  wire logic clk_sys,
	// bus lines
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_oe_n
);
	// ----------------------------------------
	// bit and byte timing
	// ----------------------------------------
	// third of a bit, long enough for the 3-cycle answer delay
	localparam int Q = 8;
	initial begin
		scl      = 1'b1;
		sda_oe_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic start();
		sda_oe_n = 1'b1;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sda_oe_n = 1'b0;
		tick(Q);
		scl = 1'b0;
		tick(Q);
	endtask
	task automatic stop();
		sda_oe_n = 1'b0;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sda_oe_n = 1'b1;
		tick(Q);
	endtask
	task automatic put(input logic b);
		sda_oe_n = b;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		scl = 1'b0;
		tick(Q);
	endtask
	task automatic get(output logic b);
		sda_oe_n = 1'b1;
		tick(Q);
		scl = 1'b1;
		tick(Q / 2);
		b = sda_line;
		tick(Q / 2);
		scl = 1'b0;
		tick(Q);
	endtask
	task automatic xbyte(input logic [7:0] v, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put(v[i]);
		get(a);
		ack = ~a;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(last);
	endtask
	// ----------------------------------------
	// transactions
	// ----------------------------------------
	task automatic wr(input logic [6:0] a, input logic [7:0] c, output logic ok);
		logic a1;
		logic a2;
		start();
		xbyte({a, 1'b0}, a1);
		xbyte(c, a2);
		stop();
		ok = a1 & a2;
	endtask
	// last low means more bytes wanted, which leaves the command incomplete
	task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic last,
		output logic ok, output logic [7:0] d);
		logic a1;
		logic a2;
		logic a3;
		start();
		xbyte({a, 1'b0}, a1);
		xbyte(c, a2);
		start();
		xbyte({a, 1'b1}, a3);
		rbyte(last, d);
		stop();
		ok = a1 & a2 & a3;
	endtask
	task automatic ara(output logic ok, output logic [7:0] d);
		start();
		xbyte({ALERT_RESP_ADDR, 1'b1}, ok);
		rbyte(1'b1, d);
		stop();
	endtask
endmodule // pmalrt_host

// ==== tb/pmalrt_top_tb.sv ====
`timescale 1ns/1ns
module pmalrt_top_tb
	import pmalrt_pkg::*;
;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [6:0] MY    = ADDR_BASE | {4'h0, STRAP};
	logic          clk_sys = 1'b0;
	logic          rst = 1'b1;
	logic          scl;
	logic          h_oe_n;
	wire logic     sda_line;
	logic          sda_out;
	logic          sda_oe_n;
	logic          fault_alert_out;
	// enables start tied low, as for a host-controlled setup
	logic          en1 = 1'b0;
	logic          en2 = 1'b0;
	logic          sync_in = 1'b0;
	logic [1:0]    in_reg = 2'b11;
	pmalrt_meas_t  meas = {8'h3C, 8'h5A, 8'hA7, 8'h1E};
	pmalrt_fault_t fault_in = '0;
	logic          pg1;
	logic          pg2;
	logic          on1;
	logic          on2;
	logic          switch_clk;
	logic          ok;
	logic [7:0]    d;
	int            n_fail = 0;
	int            total_checks = 0;
	wire logic [5:0] obs = {switch_clk, on2, on1, pg2, pg1, fault_alert_out};
	always #25 clk_sys = ~clk_sys;
	// pull-up wins unless someone drives low
	assign sda_line = !h_oe_n ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);
	pmalrt_top pmalrt_top_inst (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .fault_alert_out(fault_alert_out),
		.output_one_enable_in(en1), .output_two_enable_in(en2), .addr_strap(STRAP),
		.sync_in(sync_in), .meas(meas), .fault_in(fault_in), .rail_in_reg(in_reg),
		.output_one_power_good(pg1), .output_two_power_good(pg2), .rail_one_on(on1),
		.rail_two_on(on2), .switch_clk(switch_clk));
	pmalrt_host pmalrt_host_inst (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_oe_n(h_oe_n));
	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	task automatic give_verdict();
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_bit(input int i, input logic v);
		for (int k = 0; k < 400 && obs[i] !== v; k++) @(negedge clk_sys);
		chk($sformatf("obs%0d", i), {7'h0, v}, {7'h0, obs[i]});
		if (obs[i] !== v) give_verdict();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("reset outs", 8'h01, {2'b00, obs});
		chk("reset oe", 8'h01, {7'h0, sda_oe_n});
	endtask
	task automatic t_enable();
		en1 = 1'b1;
		wait_bit(3, 1'b1);
		wait_bit(1, 1'b1);
		cyc(10);
		chk("rail two idle", 8'h00, {6'h0, on2, pg2});
		en2 = 1'b1;
		wait_bit(4, 1'b1);
		wait_bit(2, 1'b1);
		in_reg = 2'b01;
		wait_bit(2, 1'b0);
		chk("pg one kept", 8'h01, {7'h0, pg1});
		in_reg = 2'b11;
		wait_bit(2, 1'b1);
	endtask
	task automatic t_reads();
		logic [7:0] cmds [4] = '{CMD_READ_VIN, CMD_READ_VOUT, CMD_READ_IOUT, CMD_READ_TEMP};
		logic [7:0] exps [4] = '{8'h3C, 8'h5A, 8'hA7, 8'h1E};
		for (int i = 0; i < 4; i++) begin
			pmalrt_host_inst.rd(MY, cmds[i], 1'b1, ok, d);
			chk("read ack", 8'h01, {7'h0, ok});
			chk("read data", exps[i], d);
		end
		pmalrt_host_inst.rd(MY ^ 7'h03, CMD_READ_VIN, 1'b1, ok, d);
		chk("foreign ack", 8'h00, {7'h0, ok});
		pmalrt_host_inst.ara(ok, d);
		chk("idle ara ack", 8'h00, {7'h0, ok});
	endtask
	task automatic t_alert();
		fault_in.ot = 1'b1;
		wait_bit(0, 1'b0);
		fault_in = '0;
		cyc(20);
		chk("alert held", 8'h00, {7'h0, fault_alert_out});
		pmalrt_host_inst.ara(ok, d);
		chk("ara ack", 8'h01, {7'h0, ok});
		chk("ara addr", {MY, 1'b0}, d);
		chk("alert after ara", 8'h00, {7'h0, fault_alert_out});
		pmalrt_host_inst.rd(MY, CMD_STATUS, 1'b1, ok, d);
		chk("status", 8'h02, d);
		pmalrt_host_inst.wr(MY, CMD_CLEAR, ok);
		chk("clear ack", 8'h01, {7'h0, ok});
		wait_bit(0, 1'b1);
		pmalrt_host_inst.ara(ok, d);
		chk("ara after clear", 8'h00, {7'h0, ok});
	endtask
	task automatic t_ov();
		fault_in.ov1 = 1'b1;
		wait_bit(1, 1'b0);
		wait_bit(3, 1'b0);
		fault_in = '0;
		cyc(20);
		chk("ov latched", 8'h04, {5'h0, pg2, on1, pg1});
		chk("ov alert", 8'h00, {7'h0, fault_alert_out});
		// the latch lets go only when the whole module is re-enabled
		en1 = 1'b0;
		en2 = 1'b0;
		cyc(10);
		en1 = 1'b1;
		en2 = 1'b1;
		wait_bit(3, 1'b1);
		wait_bit(1, 1'b1);
		pmalrt_host_inst.wr(MY, CMD_CLEAR, ok);
		wait_bit(0, 1'b1);
	endtask
	task automatic t_halt();
		pmalrt_host_inst.rd(MY, CMD_READ_VIN, 1'b0, ok, d);
		pmalrt_host_inst.rd(MY, CMD_READ_VIN, 1'b1, ok, d);
		chk("halted ack", 8'h00, {7'h0, ok});
		en1 = 1'b0;
		en2 = 1'b0;
		cyc(10);
		en1 = 1'b1;
		en2 = 1'b1;
		cyc(10);
		pmalrt_host_inst.rd(MY, CMD_READ_VOUT, 1'b1, ok, d);
		chk("resumed ack", 8'h01, {7'h0, ok});
		chk("resumed data", 8'h5A, d);
	endtask
	task automatic t_sync();
		logic v;
		v = switch_clk;
		repeat (3) begin
			sync_in = 1'b1;
			cyc(6);
			sync_in = 1'b0;
			cyc(6);
		end
		chk("switch clock", {7'h0, ~v}, {7'h0, switch_clk});
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(6);
		t_reset();
		rst = 1'b0;
		cyc(4);
		t_enable();
		t_reads();
		t_alert();
		t_ov();
		t_halt();
		t_sync();
		give_verdict();
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_fail++;
		give_verdict();
	end
endmodule // pmalrt_top_tb
